// ---- suvm_ctrl.sv ----
// module: unknown-vlan forwarding and mac filter/back-off control registers
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
// Overview of operation
// - global enable forwards unknown vlan frames
// - bits 2..0 select ports 3..1
// - enable and port bits reset to zero
// - precedence: vlan, then unicast, then multicast
// - alternate back-off only on half-duplex ports
// - length check discards mismatched short-length frames
// - drop mode set: ethertype or address drops
// - drop mode clear: ethertype and address drops
// - aggressive back-off on half-duplex when set
module suvm_ctrl #(
  parameter int NUM_PORTS = 3
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // avalon-mm slave
  input  wire logic [11:0]          avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  output logic      [1:0]           avs_response,
  // frame classification request (same clock)
  input  wire logic                 frm_valid,
  input  wire logic                 frm_unknown_vlan,
  input  wire logic                 frm_unknown_ucast,
  input  wire logic                 frm_unknown_mcast,
  input  wire logic [15:0]          frm_type_len,
  input  wire logic [15:0]          frm_payload_len,
  input  wire logic [47:0]          frm_dest_addr,
  input  wire logic [NUM_PORTS-1:0] frm_fwd_ucast,
  input  wire logic [NUM_PORTS-1:0] frm_fwd_mcast,
  input  wire logic [NUM_PORTS-1:0] frm_fwd_known,
  // per-port duplex status (same clock)
  input  wire logic [NUM_PORTS-1:0] port_half_duplex,
  // verdict
  output logic                      vrd_valid,
  output logic                      vrd_drop,
  output logic      [NUM_PORTS-1:0] vrd_port_mask,
  output logic      [1:0]           vrd_class,
  // back-off controls toward the port macs
  output logic      [NUM_PORTS-1:0] port_alt_backoff,
  output logic      [NUM_PORTS-1:0] port_aggr_backoff
);

  // ****************
  // registers
  // ****************
  logic                 vlan_fwd_en;
  logic [NUM_PORTS-1:0] vlan_fwd_ports;
  logic [7:0]           mac_ctrl;
  logic [2:0]           frames_dropped;
  logic                 bus_ack;
  logic                 req;
  logic                 hit;
  logic [31:0]          next_readdata;

  assign req = (avs_read | avs_write) & ~bus_ack;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == suvm_pkg::VLAN_FWD_OFFSET) || (a == suvm_pkg::MAC_CTRL_OFFSET) ||
             (a == suvm_pkg::VERDICT_OFFSET);
  endfunction

  assign hit = mapped(avs_address);

  // ****************
  // write decode
  // ****************
  // a write lands only on the edge that sees the acknowledge; the master holds
  // its request through that edge, and bus_ack masks req there, so a held
  // request is applied exactly once and never taken a second time
  logic wr_vlan;
  logic wr_mac;

  function automatic logic wr_sel(input logic [11:0] a, input logic [11:0] o);
    wr_sel = (a == o);
  endfunction

  assign wr_vlan = clk_en && bus_ack && avs_write &&
                   wr_sel(avs_address, suvm_pkg::VLAN_FWD_OFFSET);
  assign wr_mac  = clk_en && bus_ack && avs_write &&
                   wr_sel(avs_address, suvm_pkg::MAC_CTRL_OFFSET);

  // ****************
  // bus handshake
  // ****************
  // one wait cycle per access: ack high the cycle after the request is seen
  // waitrequest, read data and response all stand for that one cycle only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
    end else if (clk_en) begin
      bus_ack <= req;
    end
  end

  // ****************
  // read mux
  // ****************
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      suvm_pkg::VLAN_FWD_OFFSET: begin
        next_readdata[suvm_pkg::VLAN_EN_BIT] = vlan_fwd_en;
        next_readdata[NUM_PORTS-1:0] = vlan_fwd_ports;
      end
      suvm_pkg::MAC_CTRL_OFFSET: begin
        next_readdata[7:0] = mac_ctrl;
      end
      suvm_pkg::VERDICT_OFFSET: begin
        next_readdata[2:0] = frames_dropped;
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      avs_response    <= 2'h0;
    end else if (clk_en) begin
      avs_waitrequest <= ~req;
      avs_readdata    <= (req && avs_read) ? next_readdata : 32'h0000_0000;
      avs_response    <= (req && !hit) ? 2'h3 : 2'h0;
    end
  end

  // ****************
  // register storage
  // ****************
  // writes take effect on the acknowledging edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vlan_fwd_en    <= suvm_pkg::VLAN_FWD_RESET[3];
      vlan_fwd_ports <= suvm_pkg::VLAN_FWD_RESET[NUM_PORTS-1:0];
    end else if (wr_vlan) begin
      if (avs_byteenable[3]) begin
        vlan_fwd_en <= avs_writedata[suvm_pkg::VLAN_EN_BIT];
      end
      if (avs_byteenable[0]) begin
        vlan_fwd_ports <= avs_writedata[NUM_PORTS-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mac_ctrl <= suvm_pkg::MAC_CTRL_RESET;
    end else if (wr_mac && avs_byteenable[0]) begin
      mac_ctrl <= avs_writedata[7:0];
    end
  end

  // ****************
  // frame verdict
  // ****************
  logic                 is_fc_type;
  logic                 is_fc_addr;
  logic                 fc_drop;
  logic                 len_drop;
  logic                 next_drop;
  logic [NUM_PORTS-1:0] next_mask;
  logic [1:0]           next_class;
  logic                 alt_backoff_en;
  logic                 len_check_en;
  logic                 fc_drop_any;
  logic                 aggr_backoff_en;

  // named views of the control byte; bits 6:4 and 2 are plain storage
  assign alt_backoff_en  = mac_ctrl[suvm_pkg::ALT_BACKOFF_BIT];
  assign len_check_en    = mac_ctrl[suvm_pkg::LEN_CHECK_BIT];
  assign fc_drop_any     = mac_ctrl[suvm_pkg::FC_DROP_BIT];
  assign aggr_backoff_en = mac_ctrl[suvm_pkg::AGGR_BACKOFF_BIT];

  // ****************
  // frame filters
  // ****************
  assign is_fc_type = (frm_type_len == suvm_pkg::FC_ETHERTYPE);
  assign is_fc_addr = (frm_dest_addr == suvm_pkg::FC_DEST_ADDR);
  assign fc_drop = fc_drop_any ? (is_fc_type | is_fc_addr)
                               : (is_fc_type & is_fc_addr);
  assign len_drop = len_check_en &&
                    (frm_type_len < suvm_pkg::LEN_FIELD_MAX) &&
                    (frm_payload_len != frm_type_len);

  // ****************
  // classification
  // ****************
  // precedence: unknown vlan, then unicast, then multicast, else known
  // a dropped frame keeps its class but shows an empty port mask
  always_comb begin
    next_mask  = frm_fwd_known;
    next_class = suvm_pkg::SUVM_CLASS_KNOWN;
    if (frm_unknown_vlan) begin
      next_class = suvm_pkg::SUVM_CLASS_VLAN;
      next_mask  = vlan_fwd_en ? vlan_fwd_ports : '0;
    end else if (frm_unknown_ucast) begin
      next_class = suvm_pkg::SUVM_CLASS_UCAST;
      next_mask  = frm_fwd_ucast;
    end else if (frm_unknown_mcast) begin
      next_class = suvm_pkg::SUVM_CLASS_MCAST;
      next_mask  = frm_fwd_mcast;
    end
    next_drop = fc_drop | len_drop | (next_mask == '0);
    if (next_drop) begin
      next_mask = '0;
    end
  end

  // ****************
  // verdict outputs
  // ****************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vrd_valid <= 1'b0;
    end else if (clk_en) begin
      vrd_valid <= frm_valid;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vrd_drop <= 1'b0;
    end else if (clk_en) begin
      vrd_drop <= frm_valid & next_drop;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vrd_port_mask <= '0;
    end else if (clk_en) begin
      vrd_port_mask <= frm_valid ? next_mask : '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vrd_class <= 2'h0;
    end else if (clk_en) begin
      vrd_class <= frm_valid ? next_class : 2'h0;
    end
  end

  // ****************
  // drop counter
  // ****************
  // saturating drop counter, visible to software; it stops at its top value
  // so a burst of drops cannot wrap round to a misleading small count
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      frames_dropped <= 3'h0;
    end else if (clk_en && frm_valid && next_drop && frames_dropped != 3'h7) begin
      frames_dropped <= frames_dropped + 3'h1;
    end
  end

  // ****************
  // back-off controls
  // ****************
  // one flop pair per port; a port sees neither mode from the cycle after it turns full duplex, so the
  // port macs need no duplex qualification of their own
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          port_alt_backoff[gp] <= 1'b0;
        end else if (clk_en) begin
          port_alt_backoff[gp] <= port_half_duplex[gp] & alt_backoff_en;
        end
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          port_aggr_backoff[gp] <= 1'b0;
        end else if (clk_en) begin
          port_aggr_backoff[gp] <= port_half_duplex[gp] & aggr_backoff_en;
        end
      end
    end
  endgenerate

endmodule // suvm_ctrl

// ---- suvm_pkg.sv ----
// package: register map, field positions, reset values and frame constants
package suvm_pkg;

  // ****************
  // register map
  // ****************
  localparam logic [11:0] VLAN_FWD_OFFSET  = 12'h328;
  localparam logic [11:0] MAC_CTRL_OFFSET  = 12'h330;
  localparam logic [11:0] PORT_CFG_OFFSET  = 12'h340;
  localparam logic [11:0] FRAME_IN_OFFSET  = 12'h344;
  localparam logic [11:0] VERDICT_OFFSET   = 12'h348;

  // ****************
  // field positions
  // ****************
  localparam int VLAN_EN_BIT     = 31;
  localparam int ALT_BACKOFF_BIT = 7;
  localparam int LEN_CHECK_BIT   = 3;
  localparam int FC_DROP_BIT     = 1;
  localparam int AGGR_BACKOFF_BIT = 0;

  // ****************
  // reset values
  // ****************
  localparam logic [3:0]  VLAN_FWD_RESET = 4'h0;
  localparam logic [7:0]  MAC_CTRL_RESET = 8'h0E;
  localparam logic [2:0]  PORT_CFG_RESET = 3'h0;

  // ****************
  // frame constants
  // ****************
  localparam logic [15:0] FC_ETHERTYPE   = 16'h8808;
  localparam logic [47:0] FC_DEST_ADDR   = 48'h0180C2000001;
  localparam logic [15:0] LEN_FIELD_MAX  = 16'h05DC;

  typedef enum logic [1:0] {
    SUVM_CLASS_VLAN,
    SUVM_CLASS_UCAST,
    SUVM_CLASS_MCAST,
    SUVM_CLASS_KNOWN
  } suvm_class_t;

endpackage

// ---- suvm_ctrl_asserts.sv ----
// checker: verdict and back-off assertions on the control block ports
`timescale 1ns/1ps
module suvm_ctrl_asserts #(
  parameter int NUM_PORTS = 3
) (
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic                 frm_valid,
  input wire logic                 frm_unknown_vlan,
  input wire logic                 frm_unknown_ucast,
  input wire logic                 frm_unknown_mcast,
  input wire logic [15:0]          frm_type_len,
  input wire logic [47:0]          frm_dest_addr,
  input wire logic [NUM_PORTS-1:0] port_half_duplex,
  input wire logic                 vrd_valid,
  input wire logic                 vrd_drop,
  input wire logic [NUM_PORTS-1:0] vrd_port_mask,
  input wire logic [1:0]           vrd_class,
  input wire logic [NUM_PORTS-1:0] port_alt_backoff,
  input wire logic [NUM_PORTS-1:0] port_aggr_backoff
);
  // ****************
  // assertions
  // ****************
  logic nv;
  assign nv = frm_valid && !frm_unknown_vlan;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_vrd_follows: assert property (frm_valid |=> vrd_valid)
    else $error("verdict missing after frame");
  a_vlan_first: assert property (frm_valid && frm_unknown_vlan |=> vrd_class == 2'h0)
    else $error("unknown vlan class not first");
  a_ucast_next: assert property (
    nv && frm_unknown_ucast |=> vrd_class == 2'h1) else $error("unicast class wrong");
  a_mcast_last: assert property (
    nv && !frm_unknown_ucast && frm_unknown_mcast |=> vrd_class == 2'h2)
    else $error("multicast class wrong");
  a_fc_both: assert property (
    frm_valid && frm_type_len == suvm_pkg::FC_ETHERTYPE &&
    frm_dest_addr == suvm_pkg::FC_DEST_ADDR |=> vrd_drop) else $error("pause frame passed");
  a_drop_nomask: assert property (vrd_drop |-> vrd_valid && vrd_port_mask == '0)
    else $error("dropped frame has ports");
  a_alt_half: assert property ((port_alt_backoff & ~$past(port_half_duplex)) == '0)
    else $error("alternate back-off on full duplex");
  a_aggr_half: assert property ((port_aggr_backoff & ~$past(port_half_duplex)) == '0)
    else $error("aggressive back-off on full duplex");
endmodule // suvm_ctrl_asserts
bind suvm_ctrl suvm_ctrl_asserts #(.NUM_PORTS(NUM_PORTS)) u_suvm_ctrl_asserts (.mclk(mclk),
  .rst_n(rst_n), .frm_valid(frm_valid), .frm_unknown_vlan(frm_unknown_vlan),
  .frm_unknown_ucast(frm_unknown_ucast), .frm_unknown_mcast(frm_unknown_mcast),
  .frm_type_len(frm_type_len), .frm_dest_addr(frm_dest_addr),
  .port_half_duplex(port_half_duplex), .vrd_valid(vrd_valid), .vrd_drop(vrd_drop),
  .vrd_port_mask(vrd_port_mask), .vrd_class(vrd_class), .port_alt_backoff(port_alt_backoff),
  .port_aggr_backoff(port_aggr_backoff));

// ---- suvm_ctrl_tb_top.sv ----
// testbench: register and verdict tests for the control block
`timescale 1ns/1ps
module suvm_ctrl_tb_top;
  // ****************
  // stimulus and checks
  // ****************
  localparam logic [47:0] DA0 = 48'h020000000055;
  localparam logic [47:0] FD  = suvm_pkg::FC_DEST_ADDR;
  localparam logic [15:0] ET  = suvm_pkg::FC_ETHERTYPE;
  localparam logic [11:0] VA  = suvm_pkg::VLAN_FWD_OFFSET;
  localparam logic [11:0] MA  = suvm_pkg::MAC_CTRL_OFFSET;
  logic        mclk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, frm_valid = 1'b0;
  logic        avs_waitrequest, vrd_valid, vrd_drop;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [1:0]  avs_response, vrd_class, r;
  logic [2:0]  k = 3'h0, hd = 3'h0, vrd_port_mask, port_alt_backoff, port_aggr_backoff;
  logic [15:0] tl = 16'h0, pl = 16'h0;
  logic [47:0] da = 48'h0;
  int          err_total = 0, n_compared = 0;
  always #2.5 mclk = ~mclk;
  suvm_ctrl u_suvm_ctrl (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .frm_valid(frm_valid), .frm_unknown_vlan(k[0]),
    .frm_unknown_ucast(k[1]), .frm_unknown_mcast(k[2]), .frm_type_len(tl),
    .frm_payload_len(pl), .frm_dest_addr(da), .frm_fwd_ucast(3'h3), .frm_fwd_mcast(3'h6),
    .frm_fwd_known(3'h7), .port_half_duplex(hd), .vrd_valid(vrd_valid), .vrd_drop(vrd_drop),
    .vrd_port_mask(vrd_port_mask), .vrd_class(vrd_class), .port_alt_backoff(port_alt_backoff),
    .port_aggr_backoff(port_aggr_backoff));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is seen low, then releases it
  task automatic bus(input logic rd, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    chk(32'(n), 32'h2);
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    bus(1'b1, a, 32'h0);
    chk(q, e);
    chk(32'(r), 32'(er));
  endtask
  task automatic frm(input logic [2:0] kk, input logic [15:0] t, input logic [15:0] p,
    input logic [47:0] d, input logic [5:0] e);
    @(posedge mclk);
    frm_valid <= 1'b1;
    k <= kk;
    tl <= t;
    pl <= p;
    da <= d;
    @(posedge mclk);
    frm_valid <= 1'b0;
    #1 chk(32'({vrd_valid, vrd_drop, vrd_port_mask, vrd_class}), 32'({1'b1, e}));
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #50000;
    err_total++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rd(VA, 32'h0, 2'h0);
    rd(MA, 32'h0E, 2'h0);
    rd(12'h3FC, 32'h0, 2'h3);
    frm(3'h1, 16'h0800, 16'h0, DA0, 6'h20);
    bus(1'b0, VA, 32'h80000000);
    frm(3'h1, 16'h0800, 16'h0, DA0, 6'h20);
    for (int p = 1; p < 8; p++) begin
      bus(1'b0, VA, 32'h80000000 | p);
      frm(3'h7, 16'h0800, 16'h0, DA0, {1'b0, 3'(p), 2'h0});
    end
    bus(1'b0, VA, 32'h7);
    frm(3'h1, 16'h0800, 16'h0, DA0, 6'h20);
    frm(3'h6, 16'h0800, 16'h0, DA0, 6'h0D);
    frm(3'h4, 16'h0800, 16'h0, DA0, 6'h1A);
    $display("test vlan done");
    frm(3'h0, ET, 16'h0, DA0, 6'h23);
    frm(3'h0, 16'h0800, 16'h0, FD, 6'h23);
    frm(3'h0, 16'h0800, 16'h0, DA0, 6'h1F);
    bus(1'b0, MA, 32'h0C);
    frm(3'h0, ET, 16'h0, DA0, 6'h1F);
    frm(3'h0, 16'h0800, 16'h0, FD, 6'h1F);
    frm(3'h0, ET, 16'h0, FD, 6'h23);
    $display("test flow control done");
    frm(3'h0, 16'h05DB, 16'h05DA, DA0, 6'h23);
    frm(3'h0, 16'h05DB, 16'h05DB, DA0, 6'h1F);
    frm(3'h0, 16'h05DC, 16'h0, DA0, 6'h1F);
    bus(1'b0, MA, 32'h04);
    frm(3'h0, 16'h05DB, 16'h05DA, DA0, 6'h1F);
    $display("test length done");
    @(posedge mclk) hd <= 3'h5;
    bus(1'b0, MA, 32'h81);
    repeat (2) @(posedge mclk);
    #1 chk(32'({port_alt_backoff, port_aggr_backoff}), 32'h2D);
    @(posedge mclk) hd <= 3'h2;
    bus(1'b0, MA, 32'h80);
    repeat (2) @(posedge mclk);
    #1 chk(32'({port_alt_backoff, port_aggr_backoff}), 32'h10);
    $display("test back-off done");
    bus(1'b0, suvm_pkg::VERDICT_OFFSET, 32'h0);
    rd(suvm_pkg::VERDICT_OFFSET, 32'h7, 2'h0);
    $display("test counter done");
    complete_run;
  end
endmodule // suvm_ctrl_tb_top
